// [verilog/dccr_pkg.sv]
// Package: register map, field layout, reset values and carrier types for the DAC channel control block
package dccr_pkg;

	// Control word layout
	localparam int WORD_W      = 16;                        // Serial control word width
	localparam int ADDR_W      = 7;                         // Address field width
	localparam int DATA_W      = 9;                         // Data field width
	localparam int NUM_REGS    = 13;                        // Stored registers at 00h..0Ch
	localparam int NUM_PAIRS   = 3;                         // Stereo DAC pairs
	localparam int NUM_CHAN    = 6;                         // Mono DAC channels
	localparam int SAMPLE_W    = 24;                        // Audio sample width
	localparam int ATT_W       = 8;                         // Attenuation code width

	// Register offsets
	localparam logic [6:0] ADDR_DAC1_LEFT_ATT   = 7'h00;
	localparam logic [6:0] ADDR_DAC1_RIGHT_ATT  = 7'h01;
	localparam logic [6:0] ADDR_CHANNEL_CTRL    = 7'h02;
	localparam logic [6:0] ADDR_INTERFACE_CTRL  = 7'h03;
	localparam logic [6:0] ADDR_DAC2_LEFT_ATT   = 7'h04;
	localparam logic [6:0] ADDR_DAC2_RIGHT_ATT  = 7'h05;
	localparam logic [6:0] ADDR_DAC3_LEFT_ATT   = 7'h06;
	localparam logic [6:0] ADDR_DAC3_RIGHT_ATT  = 7'h07;
	localparam logic [6:0] ADDR_ALL_CHAN_ATT    = 7'h08;
	localparam logic [6:0] ADDR_FILTER_MUTE     = 7'h09;
	localparam logic [6:0] ADDR_RATE_POWER      = 7'h0a;
	localparam logic [6:0] ADDR_ADC_FORMAT      = 7'h0b;
	localparam logic [6:0] ADDR_ADC_INTERFACE   = 7'h0c;
	localparam logic [6:0] ADDR_SOFT_RESET      = 7'h1f;

	// Field positions
	localparam int ATT_UPDATE_BIT = 8;                      // Latch pending attenuations
	localparam int CTL_ATC_BIT    = 3;                      // right_uses_left_atten
	localparam int CTL_IZD_BIT    = 4;                      // zero_run_mute_en
	localparam int CTL_ROUTE_LSB  = 5;                      // output_route_sel low bit
	localparam int ROUTE_W        = 4;                      // output_route_sel width

	// Reset values
	localparam logic [8:0] RST_ATT            = 9'h0ff;
	localparam logic [8:0] RST_CHANNEL_CTRL   = 9'h120;
	localparam logic [8:0] RST_INTERFACE_CTRL = 9'h000;
	localparam logic [8:0] RST_FILTER_MUTE    = 9'h000;
	localparam logic [8:0] RST_RATE_POWER     = 9'h080;
	localparam logic [8:0] RST_ADC_FORMAT     = 9'h040;
	localparam logic [8:0] RST_ADC_INTERFACE  = 9'h000;
	localparam logic [NUM_REGS-1:0][8:0] REG_DEFAULTS = {
		RST_ADC_INTERFACE, RST_ADC_FORMAT, RST_RATE_POWER, RST_FILTER_MUTE, RST_ATT,
		RST_ATT, RST_ATT, RST_ATT, RST_ATT, RST_INTERFACE_CTRL, RST_CHANNEL_CTRL, RST_ATT, RST_ATT};

	// Left attenuation offset of each pair; the right one follows it
	localparam logic [NUM_PAIRS-1:0][6:0] PAIR_LEFT_ATT = {ADDR_DAC3_LEFT_ATT, ADDR_DAC2_LEFT_ATT,
		ADDR_DAC1_LEFT_ATT};

	// Route source codes
	localparam logic [1:0] SRC_MUTE  = 2'h0;
	localparam logic [1:0] SRC_LEFT  = 2'h1;
	localparam logic [1:0] SRC_RIGHT = 2'h2;
	localparam logic [1:0] SRC_AVG   = 2'h3;

	// Zero run detection
	localparam int         ZCNT_W       = 11;
	localparam logic [10:0] ZERO_RUN_LEN = 11'h400;         // 1024 consecutive zeros

	// midrail_level: signed code that puts the DAC at mid-rail
	localparam logic [SAMPLE_W-1:0] MIDRAIL_LEVEL = 24'h000000;

	// Buffer depth
	localparam int FIFO_DEPTH = 32;

	// Control word as delivered by the serial port
	typedef struct packed {
		logic [ADDR_W-1:0] addr;                            // Bits 15:9
		logic [DATA_W-1:0] data;                            // Bits 8:0
	} dccr_word_t;

	// Stereo input sample for one pair
	typedef struct packed {
		logic [1:0]          pair;
		logic [SAMPLE_W-1:0] left;
		logic [SAMPLE_W-1:0] right;
	} dccr_in_t;

	// Routed sample with its attenuation and mute state
	typedef struct packed {
		logic [1:0]          pair;
		logic [SAMPLE_W-1:0] left;
		logic [SAMPLE_W-1:0] right;
		logic [ATT_W-1:0]    left_att;
		logic [ATT_W-1:0]    right_att;
		logic                left_mute;
		logic                right_mute;
	} dccr_out_t;

	// All state of the control block
	typedef struct packed {
		logic [NUM_REGS-1:0][DATA_W-1:0] regs;
		logic [NUM_CHAN-1:0][ATT_W-1:0]  att_act;
		logic [NUM_CHAN-1:0][ZCNT_W-1:0] zcnt;
		logic [NUM_CHAN-1:0]             zflag;
		logic                            out_valid;
		dccr_out_t                       out;
	} dccr_state_t;

endpackage : dccr_pkg

// [verilog/dccr_fifo.sv]
// Sample buffer: flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dccr_fifo #(
	parameter int WIDTH = 50,
	parameter int DEPTH = 32
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	// Pointers carry one extra bit so full and empty differ
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wr;
		logic [AW:0]                 rd;
		logic                        ready;
	} dccr_fifo_state_t;

	dccr_fifo_state_t s_q;                              // Registered state
	dccr_fifo_state_t s_d;                              // Next state
	logic             push;                             // Write accepted
	logic             pop;                              // Read accepted
	logic [AW:0]      used;                             // Occupancy after this cycle

	assign in_ready  = s_q.ready;
	assign out_valid = (s_q.wr != s_q.rd);
	assign out_data  = s_q.mem[s_q.rd[AW-1:0]];
	assign push      = in_valid && s_q.ready;
	assign pop       = out_valid && out_ready;

	// Ready is registered, so it looks one cycle ahead to stay honest
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr[AW-1:0]] = in_data;
			s_d.wr = s_q.wr + 1'b1;
		end
		if (pop) begin
			s_d.rd = s_q.rd + 1'b1;
		end
		used = s_d.wr - s_d.rd;
		s_d.ready = (used < (AW+1)'(DEPTH));
		if (reset) begin
			s_d.wr = '0;
			s_d.rd = '0;
			s_d.ready = 1'b0;
		end
	end

	// Single register stage
	always_ff @(posedge clock) begin
		s_q <= s_d;
	end
endmodule : dccr_fifo

// [verilog/dccr_top.sv]
// DAC channel control: register bank, attenuation sharing, zero-run mute and output routing
//
// Behaviour
// R01: Control word: address bits 15:9, data 8:0
// R02: Host writes zero to unused bits
// R03: Sharing bit gives right DACs left attenuation
// R04: Sharing change needs no attenuation update
// R05: 1024 zero samples mute channel to mid-rail
// R06: First non-zero sample unmutes the channel
// R07: Route field bits 8:5, resets to 1001
// R08: Route codes: mute, left, right, average
// R09: Write to 1Fh restores all defaults
`timescale 1ns/1ps
module dccr_top
	import dccr_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                reset,
	input  wire logic                word_valid,
	input  wire dccr_pkg::dccr_word_t word,
	input  wire logic                in_valid,
	output logic                     in_ready,
	input  wire dccr_pkg::dccr_in_t  in_sample,
	output logic                     out_valid,
	input  wire logic                out_ready,
	output dccr_pkg::dccr_out_t      out_sample,
	output logic [5:0]               zero_flags,
	output logic [8:0]               channel_control,
	output logic [8:0]               interface_control,
	output logic [8:0]               filter_mute_control,
	output logic [8:0]               rate_power_control,
	output logic [8:0]               adc_format_control,
	output logic [8:0]               adc_interface_control,
	output logic [8:0]               all_channel_att
);
	import dccr_pkg::*;

	localparam int IN_W = $bits(dccr_in_t);

	dccr_state_t s_q;                                  // Registered state
	dccr_state_t s_d;                                  // Next state

	// Buffer side signals
	logic        buf_valid;                            // Sample waiting in the buffer
	logic        buf_ready;                            // Output stage can take a sample
	dccr_in_t    buf_sample;                           // Head of the buffer
	logic [IN_W-1:0] buf_bits;                         // Raw head bits

	// Per channel zero detection
	logic [NUM_CHAN-1:0][ZCNT_W-1:0] zcnt_next;        // Counter after this pop
	logic [NUM_CHAN-1:0]             zflag_next;       // Run complete after this pop
	logic                            pop;              // Sample leaves the buffer
	logic                            pair_ok;          // Pair index in range

	// Control fields taken from the channel register
	logic             share_att;                       // right_uses_left_atten
	logic             zero_mute_en;                    // zero_run_mute_en
	logic [ROUTE_W-1:0] route;                         // output_route_sel

	assign share_att    = s_q.regs[ADDR_CHANNEL_CTRL][CTL_ATC_BIT];
	assign zero_mute_en = s_q.regs[ADDR_CHANNEL_CTRL][CTL_IZD_BIT];
	assign route        = s_q.regs[ADDR_CHANNEL_CTRL][CTL_ROUTE_LSB +: ROUTE_W]; // R07

	// Stall the buffer while the output holds an unaccepted sample
	assign buf_ready  = !s_q.out_valid || out_ready;
	assign pop        = buf_valid && buf_ready;
	assign buf_sample = dccr_in_t'(buf_bits);
	assign pair_ok    = (buf_sample.pair < 2'(NUM_PAIRS));

	// The buffer decouples the sample source from the consumer's pace
	dccr_fifo #(
		.WIDTH (IN_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.reset     (reset),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.in_data   (in_sample),
		.out_valid (buf_valid),
		.out_ready (buf_ready),
		.out_data  (buf_bits)
	);

	// One zero-run counter per input channel; even index is a left input
	genvar g;
	generate
		for (g = 0; g < NUM_CHAN; g++) begin : g_zero
			logic [SAMPLE_W-1:0] chan_val;             // This channel's input value
			logic                hit;                  // Sample for this channel's pair
			assign chan_val = (g % 2 == 0) ? buf_sample.left : buf_sample.right;
			assign hit      = pop && pair_ok && (buf_sample.pair == 2'(g / 2));
			always_comb begin
				zcnt_next[g] = s_q.zcnt[g];
				if (hit) begin
					if (chan_val != '0) begin
						// Any non-zero sample restarts the run
						zcnt_next[g] = '0; // R06
					end else if (s_q.zcnt[g] != ZERO_RUN_LEN) begin
						// Saturate so a long silence never wraps into an unmute
						zcnt_next[g] = s_q.zcnt[g] + 1'b1; // R05
					end
				end
				zflag_next[g] = (zcnt_next[g] == ZERO_RUN_LEN); // R05
			end
		end
	endgenerate

	// Pick one DAC source from the route code
	function automatic logic [SAMPLE_W-1:0] pick_source(
		input logic [1:0]          sel,
		input logic [SAMPLE_W-1:0] l,
		input logic [SAMPLE_W-1:0] r
	);
		logic [SAMPLE_W:0] sum;
		sum = {l[SAMPLE_W-1], l} + {r[SAMPLE_W-1], r};
		case (sel)
			SRC_MUTE:  pick_source = MIDRAIL_LEVEL;          // R08
			SRC_LEFT:  pick_source = l;                      // R08
			SRC_RIGHT: pick_source = r;                      // R08
			SRC_AVG:   pick_source = sum[SAMPLE_W:1];        // R08
			default:   pick_source = MIDRAIL_LEVEL;
		endcase
	endfunction : pick_source

	// Register writes, attenuation latching and the output stage
	always_comb begin
		logic [2:0]          p;                        // Pair of the popped sample
		logic [SAMPLE_W-1:0] l_src;                    // Routed left value
		logic [SAMPLE_W-1:0] r_src;                    // Routed right value
		logic                l_mute;                   // Left DAC held at mid-rail
		logic                r_mute;                   // Right DAC held at mid-rail
		p      = '0;
		l_src  = '0;
		r_src  = '0;
		l_mute = 1'b0;
		r_mute = 1'b0;
		s_d    = s_q;

		// Control word: address in the top seven bits, data below
		if (word_valid) begin // R01
			if (word.addr == ADDR_SOFT_RESET) begin
				// Any value written here restores every default
				s_d.regs = REG_DEFAULTS; // R09
				for (int c = 0; c < NUM_CHAN; c++) begin
					s_d.att_act[c] = RST_ATT[ATT_W-1:0]; // R09
				end
			end else if (word.addr < 7'(NUM_REGS)) begin
				// Stored as written; unused bits are the host's to keep at zero
				s_d.regs[word.addr[3:0]] = word.data; // R02
				if (word.addr == ADDR_ALL_CHAN_ATT) begin
					// One write loads the same code into all six channels
					for (int k = 0; k < NUM_PAIRS; k++) begin
						s_d.regs[PAIR_LEFT_ATT[k][3:0]]        = word.data;
						s_d.regs[PAIR_LEFT_ATT[k][3:0] + 4'h1] = word.data;
					end
				end
				// Update bit on an attenuation write latches every pending code
				if (word.data[ATT_UPDATE_BIT] && (word.addr <= ADDR_ALL_CHAN_ATT) &&
					(word.addr != ADDR_CHANNEL_CTRL) && (word.addr != ADDR_INTERFACE_CTRL)) begin
					for (int k = 0; k < NUM_PAIRS; k++) begin
						s_d.att_act[2*k]   = s_d.regs[PAIR_LEFT_ATT[k][3:0]][ATT_W-1:0];
						s_d.att_act[2*k+1] = s_d.regs[PAIR_LEFT_ATT[k][3:0] + 4'h1][ATT_W-1:0];
					end
				end
			end
			// Other addresses are ignored
		end

		// Output handshake: a taken sample clears valid unless a new one replaces it
		if (s_q.out_valid && out_ready) begin
			s_d.out_valid = 1'b0;
		end

		// Zero counters move only with popped samples
		s_d.zcnt  = zcnt_next;
		s_d.zflag = zflag_next;

		if (pop && pair_ok) begin
			p  = {1'b0, buf_sample.pair};
			l_src = pick_source(route[1:0], buf_sample.left, buf_sample.right); // R08
			r_src = pick_source(route[3:2], buf_sample.left, buf_sample.right); // R08
			// Mute follows the DAC's own-side input channel of the pair
			l_mute = zero_mute_en && zflag_next[2*p];          // R05
			r_mute = zero_mute_en && zflag_next[2*p+1];        // R05
			s_d.out_valid      = 1'b1;
			s_d.out.pair       = buf_sample.pair;
			s_d.out.left       = l_mute ? MIDRAIL_LEVEL : l_src; // R05
			s_d.out.right      = r_mute ? MIDRAIL_LEVEL : r_src; // R05
			s_d.out.left_mute  = l_mute;
			s_d.out.right_mute = r_mute;
			s_d.out.left_att   = s_q.att_act[2*p];
			// Sharing is looked up per sample, so it acts on the next one with no update
			s_d.out.right_att  = share_att ? s_q.att_act[2*p] : s_q.att_act[2*p+1]; // R03 R04
		end

		// Synchronous reset puts every register at its default
		if (reset) begin
			s_d.regs      = REG_DEFAULTS; // R07
			s_d.zcnt      = '0;
			s_d.zflag     = '0;
			s_d.out_valid = 1'b0;
			s_d.out       = '0;
			for (int c = 0; c < NUM_CHAN; c++) begin
				s_d.att_act[c] = RST_ATT[ATT_W-1:0];
			end
		end
	end

	// Single register stage for all state
	always_ff @(posedge clock) begin
		s_q <= s_d;
	end

	// Outputs come straight from the state register
	assign out_valid             = s_q.out_valid;
	assign out_sample            = s_q.out;
	assign zero_flags            = s_q.zflag;
	assign channel_control       = s_q.regs[ADDR_CHANNEL_CTRL];
	assign interface_control     = s_q.regs[ADDR_INTERFACE_CTRL];
	assign filter_mute_control   = s_q.regs[ADDR_FILTER_MUTE];
	assign rate_power_control    = s_q.regs[ADDR_RATE_POWER];
	assign adc_format_control    = s_q.regs[ADDR_ADC_FORMAT];
	assign adc_interface_control = s_q.regs[ADDR_ADC_INTERFACE];
	assign all_channel_att       = s_q.regs[ADDR_ALL_CHAN_ATT];
endmodule : dccr_top

// [test/dccr_top_sva.sv]
// Checker: port-level assertions of the DAC channel control block
`timescale 1ns/1ps
module dccr_top_sva
	import dccr_pkg::*;
(
	input wire logic                 clock,
	input wire logic                 reset,
	input wire logic                 word_valid,
	input wire dccr_pkg::dccr_word_t word,
	input wire logic                 in_valid,
	input wire logic                 in_ready,
	input wire dccr_pkg::dccr_in_t   in_sample,
	input wire logic                 out_valid,
	input wire dccr_pkg::dccr_out_t  out_sample,
	input wire logic [5:0]           zero_flags,
	input wire logic [8:0]           channel_control,
	input wire logic [8:0]           all_channel_att
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// A channel control word lands in its register one cycle later
	wr_ctrl_a: assert property (word_valid && word.addr == ADDR_CHANNEL_CTRL
		|=> channel_control == $past(word.data)) else $error("channel control write lost");
	// Leaving reset shows the listed defaults; reset itself must not mask this
	rst_dflt_a: assert property (disable iff (1'b0) $fell(reset)
		|-> channel_control == RST_CHANNEL_CTRL && all_channel_att == RST_ATT) else $error("bad reset defaults");
	// Any write to the reset address restores defaults
	soft_rst_a: assert property (word_valid && word.addr == ADDR_SOFT_RESET
		|=> channel_control == RST_CHANNEL_CTRL && all_channel_att == RST_ATT) else $error("soft reset missed");
	// Stable check skips the cycle where the output was built under the old control value
	att_share_a: assert property (out_valid && channel_control[CTL_ATC_BIT] && $stable(channel_control)
		|-> out_sample.right_att == out_sample.left_att) else $error("right attenuation not shared");
	mute_off_a: assert property (out_valid && !channel_control[CTL_IZD_BIT] && $stable(channel_control)
		|-> !out_sample.left_mute && !out_sample.right_mute) else $error("mute while disabled");
	mute_zero_a: assert property (out_valid && out_sample.left_mute
		|-> out_sample.left == MIDRAIL_LEVEL) else $error("muted left not at mid-rail");
	route_mute_a: assert property (out_valid && channel_control[6:5] == SRC_MUTE && $stable(channel_control)
		|-> out_sample.left == MIDRAIL_LEVEL) else $error("left route mute not applied");
	// A non-zero sample on pair 2 left clears its zero flag shortly
	unmute_a: assert property (in_valid && in_ready && in_sample.pair == 2'h2 && in_sample.left != '0
		|-> ##[1:100] !zero_flags[4]) else $error("zero flag not cleared");

	// Main scenarios reached
	cover property (out_valid && out_sample.left_mute);
	cover property (word_valid && word.addr == ADDR_SOFT_RESET);
	cover property (in_valid && !in_ready);
endmodule : dccr_top_sva

bind dccr_top dccr_top_sva u_sva (.clock, .reset, .word_valid, .word, .in_valid, .in_ready, .in_sample,
	.out_valid, .out_sample, .zero_flags, .channel_control, .all_channel_att);

// [test/dccr_host.sv]
// Host model: issues 16-bit control words to the register port
`timescale 1ns/1ps
module dccr_host
	import dccr_pkg::*;
(
	input  wire logic            clock,
	output logic                 word_valid,
	output dccr_pkg::dccr_word_t word
);
	// Idle port carries no meaningful word
	initial begin
		word_valid = 1'b0;
		word       = '1;
	end

	// One write; caller keeps unused data bits at zero
	task automatic put(input logic [6:0] a, input logic [8:0] d);
		@(negedge clock);
		word_valid = 1'b1;
		word       = {a, d};
		@(negedge clock);
		word_valid = 1'b0;
		word       = ~word; // Stale word inverted so it is never mistaken for valid data
		@(negedge clock);
	endtask : put
endmodule : dccr_host

// [test/dccr_top_tb_top.sv]
// Testbench: self-checking bench of the DAC channel control block
`timescale 1ns/1ps
module dccr_top_tb_top;
	import dccr_pkg::*;
	logic       clock = 1'b0;
	logic       reset = 1'b1;
	logic       word_valid;
	dccr_word_t word;
	logic       in_valid = 1'b0;
	logic       in_ready;
	dccr_in_t   in_sample = '0;
	logic       out_valid;
	logic       out_ready = 1'b1;
	dccr_out_t  out_sample;
	dccr_out_t  got;                      // Last collected output
	logic [5:0] zero_flags;
	logic [8:0] cc, ic, fm, rp, af, ai, aa; // Register views
	int         num_errors = 0;
	int         checks_done = 0;

	always #2 clock = ~clock;

	dccr_host u_host (.clock, .word_valid, .word);
	dccr_top u_dut (.clock, .reset, .word_valid, .word, .in_valid, .in_ready, .in_sample, .out_valid, .out_ready,
		.out_sample, .zero_flags, .channel_control(cc), .interface_control(ic), .filter_mute_control(fm),
		.rate_power_control(rp), .adc_format_control(af), .adc_interface_control(ai), .all_channel_att(aa));

	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	task automatic chk_reg(input string n, input logic [8:0] e, input logic [8:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk_reg

	task automatic chk_smp(input string n, input logic [23:0] e, input logic [23:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk_smp

	// A wait that ran out ends the run
	task automatic fail_to(input string n);
		num_errors++;
		$display("MISMATCH %s expected done seen timeout", n);
		test_done();
	endtask : fail_to

	// Offer one sample, then collect its output with the consumer ready
	task automatic xfer(input logic [1:0] p, input logic [23:0] l, input logic [23:0] r);
		int n;
		n = 0;
		in_valid  = 1'b1;
		in_sample = '{p, l, r};
		while (in_ready !== 1'b1 && n++ < 50) @(negedge clock);
		if (in_ready !== 1'b1) fail_to("in_ready");
		@(negedge clock);
		in_valid  = 1'b0;
		in_sample = ~in_sample;
		n = 0;
		while (out_valid !== 1'b1 && n++ < 50) @(negedge clock);
		if (out_valid !== 1'b1) fail_to("out_valid");
		got = out_sample;
		@(negedge clock);
	endtask : xfer

	task automatic chk_defaults;
		chk_reg("channel_control", RST_CHANNEL_CTRL, cc);
		chk_reg("interface_control", RST_INTERFACE_CTRL, ic);
		chk_reg("filter_mute", RST_FILTER_MUTE, fm);
		chk_reg("rate_power", RST_RATE_POWER, rp);
		chk_reg("adc_format", RST_ADC_FORMAT, af);
		chk_reg("adc_interface", RST_ADC_INTERFACE, ai);
		chk_reg("all_att", RST_ATT, aa);
	endtask : chk_defaults

	// All sixteen route codes; negative right input checks the signed average
	task automatic t_route;
		logic [23:0] e[4];
		e = '{MIDRAIL_LEVEL, 24'h000100, 24'hfffd00, 24'hffff00};
		for (int c = 0; c < 16; c++) begin
			u_host.put(ADDR_CHANNEL_CTRL, 9'(c << 5));
			xfer(2'h0, 24'h000100, 24'hfffd00);
			chk_smp("left_route", e[c % 4], got.left);
			chk_smp("right_route", e[c / 4], got.right);
		end
	endtask : t_route

	// Sharing switched on with no attenuation write in between
	task automatic t_share;
		u_host.put(ADDR_CHANNEL_CTRL, RST_CHANNEL_CTRL);
		u_host.put(ADDR_DAC1_LEFT_ATT, 9'h010);
		u_host.put(ADDR_DAC1_RIGHT_ATT, 9'h120);
		xfer(2'h0, 24'h000001, 24'h000002);
		chk_smp("left_att", 24'h000010, 24'(got.left_att));
		chk_smp("right_att", 24'h000020, 24'(got.right_att));
		u_host.put(ADDR_CHANNEL_CTRL, 9'h128);
		xfer(2'h0, 24'h000001, 24'h000002);
		chk_smp("shared_att", 24'h000010, 24'(got.right_att));
	endtask : t_share

	// Zero run on pair 2 left, mute enabled or not
	task automatic t_zero(input logic en);
		u_host.put(ADDR_CHANNEL_CTRL, en ? 9'h130 : 9'h120);
		for (int k = 1; k <= 1024; k++) begin
			xfer(2'h2, 24'h000000, 24'h000007);
			if (k >= 1023) chk_smp("left_mute", 24'(en && k == 1024), 24'(got.left_mute));
		end
		chk_smp("zero_flag", 24'h000001, 24'(zero_flags[4]));
		chk_smp("right_mute", 24'h000000, 24'(got.right_mute));
		xfer(2'h2, 24'h000005, 24'h000007);
		chk_smp("left_unmute", 24'h000000, 24'(got.left_mute));
		chk_smp("left_value", 24'h000005, got.left);
	endtask : t_zero

	// Stall until the buffer refuses, with a dropped pair code first, then drain in order
	task automatic t_fifo;
		int n;
		int m;
		m = 0;
		out_ready = 1'b0;
		in_valid  = 1'b1;
		in_sample = '{2'h3, 24'h000000, 24'h000000};
		for (n = 0; n < 100 && in_ready === 1'b1; n++) begin
			@(negedge clock);
			in_sample = '{2'h0, 24'(n + 1), 24'h000009};
		end
		in_valid = 1'b0;
		chk_smp("fifo_fill", 24'h000001, 24'(n >= FIFO_DEPTH && n < 100));
		out_ready = 1'b1;
		for (int t = 0; t < 300 && m < n - 1; t++) begin
			if (out_valid === 1'b1) begin
				m++;
				chk_smp("fifo_order", 24'(m), out_sample.left);
			end
			@(negedge clock);
		end
		if (m != n - 1) fail_to("fifo drain");
	endtask : t_fifo

	// Unmapped address ignored, then the reset address restores every default
	// The all-channel write latches 33h so the reset's return to ffh is visible
	task automatic t_soft;
		u_host.put(ADDR_CHANNEL_CTRL, 9'h000);
		u_host.put(ADDR_ALL_CHAN_ATT, 9'h133);
		u_host.put(ADDR_RATE_POWER, 9'h000);
		u_host.put(7'h0d, 9'h1ff);
		chk_reg("unmapped", 9'h000, fm);
		chk_reg("all_att_w", 9'h133, aa);
		chk_reg("rate_power_w", 9'h000, rp);
		u_host.put(ADDR_SOFT_RESET, 9'h000);
		chk_defaults();
		xfer(2'h1, 24'h000001, 24'h000002);
		chk_smp("att_after_reset", 24'h0000ff, 24'(got.left_att));
		chk_smp("right_att_after_reset", 24'h0000ff, 24'(got.right_att));
		chk_smp("out_pair", 24'h000001, 24'(got.pair));
	endtask : t_soft

	// Main sequence
	initial begin
		repeat (16) @(negedge clock);
		reset = 1'b0;
		@(negedge clock);
		chk_defaults();
		t_route();
		t_share();
		t_zero(1'b1);
		t_zero(1'b0);
		t_fifo();
		t_soft();
		test_done();
	end
endmodule : dccr_top_tb_top
